// [design/msr_readout.sv]
// Contract
// - one converter serves eight channels in fixed round-robin order
// - every channel is measured twice in each second
// - each channel holds its own sensor type
// - thermocouple and RTD values are linearized and scaled to Celsius or Fahrenheit
// - thermocouple lower limit is 0 mV, i.e. 0 C or 32 F
// - thermocouple upper limit is the type's maximum from a table
// - thermocouple flags reversed polarity at -30 C and open sensor
// - RTD covers -100 to +850 C, two- or three-wire
// - RTD flags open lead and short below 48 ohm total
// - resistance input 0..400 ohm, free span, open-lead check only
// - DC input -100..+100 mV, open-lead check only
// - two-point linear correction with four parameters per channel
// - corrected values go cyclically to each loop controller
`include "msr_defines.svh"
`default_nettype none
module msr_readout #(
   parameter int SLOT_CYC = `MSR_SLOT_NS / `MSR_CLK_NS
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic adc_start,
   output msr_pkg::msr_chan_t adc_chan,
   input wire logic adc_done,
   input wire logic signed [15:0] adc_data,
   input wire logic adc_open,
   input wire logic [15:0] adc_lead,
   output logic loop_valid,
   output msr_pkg::msr_chan_t loop_chan,
   output logic signed [15:0] loop_value,
   output logic [3:0] loop_fault,
   output logic [7:0] loop_cfg,
   output logic irq
);
   import msr_pkg::*;

   // Bus side state
   logic [7:0] cfg_q [`MSR_NCH], cfg_d [`MSR_NCH];
   logic signed [15:0] corr_q [4*`MSR_NCH], corr_d [4*`MSR_NCH];
   logic [15:0] stat_q, stat_d, ien_q, ien_d;
   logic run_q, run_d, ap_wr_q, ap_wr_d;
   logic [7:0] ap_addr_q, ap_addr_d;
   logic [31:0] hrdata_d;

   // Measurement side state
   msr_state_t st_q, st_d;
   logic [31:0] cnt_q, cnt_d;
   msr_chan_t ch_q, ch_d;
   logic signed [31:0] lin_q, lin_d;
   logic [3:0] flt_q, flt_d, f;
   logic signed [15:0] res_q [`MSR_NCH], res_d [`MSR_NCH];
   logic [3:0] rflt_q [`MSR_NCH], rflt_d [`MSR_NCH];
   logic signed [15:0] loop_value_d;

   logic ap_take, slot_tick, done_ev, flt_ev, adc_start_d, loop_valid_d;
   logic signed [31:0] raw, tc_gain, tc_max, lead2, c_in, c_out;
   logic signed [31:0] i1, o1, i2, o2, dx, dy, corr;
   msr_sensor_t styp;
   logic [7:0] ccfg;
   logic [2:0] ridx;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ap_take = hsel && hready && htrans[1];
   assign slot_tick = cnt_q == SLOT_CYC - 1;
   assign irq = |(stat_q & ien_q);
   assign adc_chan = ch_q;
   assign ccfg = cfg_q[ch_q];
   assign styp = msr_sensor_t'(ccfg[`MSR_CFG_TYPE]);
   assign ridx = ap_addr_q[4:2];

   // Register bus; writes land in the data phase, reads are prefetched
   always_comb
   begin
      logic [7:0] a;
      a = haddr[7:0];
      cfg_d = cfg_q;
      corr_d = corr_q;
      ien_d = ien_q;
      run_d = run_q;
      ap_addr_d = ap_take ? a : ap_addr_q;
      ap_wr_d = ap_take && hwrite;
      stat_d = stat_q;
      if (ap_wr_q)
      begin
         if (ap_addr_q < `MSR_OFS_CORR)
            cfg_d[ridx] = hwdata[7:0];
         else if (ap_addr_q < `MSR_OFS_RES)
            corr_d[ap_addr_q[6:2] - 5'h10] = hwdata[15:0];
         else if (ap_addr_q == `MSR_OFS_IEN)
            ien_d = hwdata[15:0];
         else if (ap_addr_q == `MSR_OFS_ICLR)
            stat_d = stat_q & ~hwdata[15:0];
         else if (ap_addr_q == `MSR_OFS_CTRL)
            run_d = hwdata[`MSR_CTRL_RUN];
      end
      // Set wins over a same-cycle clear
      if (done_ev)
         stat_d[ch_q] = 1'b1;
      if (flt_ev)
         stat_d[8 + ch_q] = 1'b1;
      hrdata_d = 32'h0;
      if (ap_take && !hwrite)
      begin
         if (a < `MSR_OFS_CORR)
            hrdata_d = {24'h0, cfg_q[a[4:2]]};
         else if (a < `MSR_OFS_RES)
            hrdata_d = {16'h0, corr_q[a[6:2] - 5'h10]};
         else if (a < `MSR_OFS_STAT)
            hrdata_d = {12'h0, rflt_q[a[4:2]], res_q[a[4:2]]};
         else if (a == `MSR_OFS_STAT)
            hrdata_d = {16'h0, stat_q};
         else if (a == `MSR_OFS_IEN)
            hrdata_d = {16'h0, ien_q};
         else if (a == `MSR_OFS_CTRL)
            hrdata_d = {31'h0, run_q};
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < `MSR_NCH; i++)
            cfg_q[i] <= `MSR_CFG_RST;
         for (int i = 0; i < 4 * `MSR_NCH; i++)
            corr_q[i] <= 16'sh0;
         stat_q <= 16'h0;
         ien_q <= 16'h0;
         run_q <= 1'b0;
         ap_addr_q <= 8'h0;
         ap_wr_q <= 1'b0;
         hrdata <= 32'h0;
      end
      else
      begin
         cfg_q <= cfg_d;
         corr_q <= corr_d;
         stat_q <= stat_d;
         ien_q <= ien_d;
         run_q <= run_d;
         ap_addr_q <= ap_addr_d;
         ap_wr_q <= ap_wr_d;
         hrdata <= hrdata_d;
      end
   end

   // Per-type thermocouple gain (0.1 C per uV, Q8) and top of range
   always_comb
   begin
      case (msr_tc_t'(ccfg[`MSR_CFG_TC]))
         MSR_L: begin tc_gain = `MSR_TC_G_L; tc_max = `MSR_TC_MAX_L; end
         MSR_J: begin tc_gain = `MSR_TC_G_J; tc_max = `MSR_TC_MAX_J; end
         MSR_K: begin tc_gain = `MSR_TC_G_K; tc_max = `MSR_TC_MAX_K; end
         MSR_N: begin tc_gain = `MSR_TC_G_N; tc_max = `MSR_TC_MAX_N; end
         MSR_S: begin tc_gain = `MSR_TC_G_S; tc_max = `MSR_TC_MAX_S; end
         MSR_R: begin tc_gain = `MSR_TC_G_R; tc_max = `MSR_TC_MAX_R; end
         MSR_T: begin tc_gain = `MSR_TC_G_T; tc_max = `MSR_TC_MAX_T; end
         MSR_W: begin tc_gain = `MSR_TC_G_W; tc_max = `MSR_TC_MAX_W; end
         MSR_E: begin tc_gain = `MSR_TC_G_E; tc_max = `MSR_TC_MAX_E; end
         default: begin tc_gain = `MSR_TC_G_K; tc_max = `MSR_TC_MAX_K; end
      endcase
   end

   // Conversion to physical value and fault checks
   always_comb
   begin
      raw = 32'(adc_data);
      lead2 = 32'({adc_lead, 1'b0});
      f = 4'h0;
      f[`MSR_FLT_OPEN] = adc_open;
      c_in = 32'sh0;
      case (styp)
         MSR_TC:
         begin
            c_in = (raw * tc_gain) >>> `MSR_LIN_SH;
            if (c_in <= `MSR_TC_REV)
               f[`MSR_FLT_POL] = 1'b1;
            if (c_in < `MSR_TC_LO)
               c_in = `MSR_TC_LO;
            if (c_in > tc_max)
            begin
               c_in = tc_max;
               f[`MSR_FLT_RANGE] = 1'b1;
            end
         end
         MSR_RTD:
         begin
            // Short check uses the total loop resistance, leads included
            if (raw < `MSR_RTD_SHORT)
               f[`MSR_FLT_SHORT] = 1'b1;
            c_in = ccfg[`MSR_CFG_3W] ? raw - lead2 : raw;
            c_in = ((c_in - `MSR_RTD_R0) * `MSR_RTD_GAIN) >>> `MSR_LIN_SH;
            if (c_in < `MSR_RTD_LO || c_in > `MSR_RTD_HI)
               f[`MSR_FLT_RANGE] = 1'b1;
            if (c_in < `MSR_RTD_LO)
               c_in = `MSR_RTD_LO;
            if (c_in > `MSR_RTD_HI)
               c_in = `MSR_RTD_HI;
         end
         MSR_RES:
         begin
            c_in = raw < 0 ? 32'sh0 : raw;
            if (c_in > `MSR_RES_HI)
               c_in = `MSR_RES_HI;
         end
         default:
         begin
            c_in = raw;
            if (c_in > `MSR_DC_LIM)
               c_in = `MSR_DC_LIM;
            if (c_in < -`MSR_DC_LIM)
               c_in = -`MSR_DC_LIM;
         end
      endcase
      c_out = c_in;
      if (ccfg[`MSR_CFG_FAHR] && (styp == MSR_TC || styp == MSR_RTD))
         c_out = c_in * `MSR_F_MUL / `MSR_F_DIV + `MSR_F_OFS;
   end

   // Two-point correction; equal input points degrade to a plain offset
   always_comb
   begin
      i1 = 32'(corr_q[{ch_q, 2'd0}]);
      o1 = 32'(corr_q[{ch_q, 2'd1}]);
      i2 = 32'(corr_q[{ch_q, 2'd2}]);
      o2 = 32'(corr_q[{ch_q, 2'd3}]);
      dx = i2 - i1;
      dy = o2 - o1;
      if (dx == 32'sh0)
         corr = lin_q - i1 + o1;
      else
         corr = o1 + (lin_q - i1) * dy / dx;
      if (corr > 32'sd32767)
         corr = 32'sd32767;
      if (corr < -32'sd32768)
         corr = -32'sd32768;
   end

   // Slot scheduler: sixteen slots a second, eight channels in turn
   always_comb
   begin
      st_d = st_q;
      cnt_d = slot_tick ? 32'h0 : cnt_q + 32'h1;
      ch_d = ch_q;
      lin_d = lin_q;
      flt_d = flt_q;
      res_d = res_q;
      rflt_d = rflt_q;
      adc_start_d = 1'b0;
      loop_valid_d = 1'b0;
      loop_value_d = loop_value;
      done_ev = 1'b0;
      flt_ev = 1'b0;
      case (st_q)
         MSR_IDLE:
            if (slot_tick && run_q)
            begin
               adc_start_d = 1'b1;
               st_d = MSR_WAIT;
            end
         MSR_WAIT:
            if (adc_done)
            begin
               lin_d = c_out;
               flt_d = f;
               st_d = MSR_CORR;
            end
         MSR_CORR:
         begin
            res_d[ch_q] = corr[15:0];
            rflt_d[ch_q] = flt_q;
            loop_valid_d = 1'b1;
            loop_value_d = corr[15:0];
            done_ev = 1'b1;
            flt_ev = |flt_q;
            ch_d = ch_q + 3'h1;
            st_d = MSR_IDLE;
         end
         default:
            st_d = MSR_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q <= MSR_IDLE;
         cnt_q <= 32'h0;
         ch_q <= 3'h0;
         lin_q <= 32'sh0;
         flt_q <= 4'h0;
         for (int i = 0; i < `MSR_NCH; i++)
         begin
            res_q[i] <= 16'sh0;
            rflt_q[i] <= 4'h0;
         end
         adc_start <= 1'b0;
         loop_valid <= 1'b0;
         loop_chan <= 3'h0;
         loop_value <= 16'sh0;
         loop_fault <= 4'h0;
         loop_cfg <= 8'h0;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ch_q <= ch_d;
         lin_q <= lin_d;
         flt_q <= flt_d;
         res_q <= res_d;
         rflt_q <= rflt_d;
         adc_start <= adc_start_d;
         loop_valid <= loop_valid_d;
         if (loop_valid_d)
         begin
            loop_chan <= ch_q;
            loop_fault <= flt_q;
            loop_cfg <= ccfg;
         end
         loop_value <= loop_value_d;
      end
   end
endmodule
`default_nettype wire

// [common/msr_defines.svh]
`ifndef MSR_DEFINES_SVH
`define MSR_DEFINES_SVH
`define MSR_NCH 8
`define MSR_SLOT_NS 62500000
`define MSR_CLK_NS 10
`define MSR_OFS_CFG 8'h00
`define MSR_OFS_CORR 8'h40
`define MSR_OFS_RES 8'hC0
`define MSR_OFS_STAT 8'hE0
`define MSR_OFS_IEN 8'hE4
`define MSR_OFS_ICLR 8'hE8
`define MSR_OFS_CTRL 8'hEC
`define MSR_CFG_TYPE 1:0
`define MSR_CFG_TC 5:2
`define MSR_CFG_FAHR 6
`define MSR_CFG_3W 7
`define MSR_CFG_RST 8'h00
`define MSR_CTRL_RUN 0
`define MSR_FLT_OPEN 0
`define MSR_FLT_POL 1
`define MSR_FLT_SHORT 2
`define MSR_FLT_RANGE 3
`define MSR_TC_LO 32'sh0
`define MSR_TC_REV -32'sd300
`define MSR_RTD_LO -32'sd1000
`define MSR_RTD_HI 32'sd8500
`define MSR_RTD_SHORT 32'sd480
`define MSR_RTD_R0 32'sd1000
`define MSR_RTD_GAIN 32'sd666
`define MSR_RES_HI 32'sd4000
`define MSR_DC_LIM 32'sd10000
`define MSR_F_OFS 32'sd320
`define MSR_F_MUL 32'sd9
`define MSR_F_DIV 32'sd5
`define MSR_LIN_SH 8
`define MSR_TC_MAX_L 32'sd9000
`define MSR_TC_MAX_J 32'sd9000
`define MSR_TC_MAX_K 32'sd13500
`define MSR_TC_MAX_N 32'sd13000
`define MSR_TC_MAX_S 32'sd17600
`define MSR_TC_MAX_R 32'sd17600
`define MSR_TC_MAX_T 32'sd4000
`define MSR_TC_MAX_W 32'sd23000
`define MSR_TC_MAX_E 32'sd10000
`define MSR_TC_G_L 32'sd49
`define MSR_TC_G_J 32'sd49
`define MSR_TC_G_K 32'sd62
`define MSR_TC_G_N 32'sd66
`define MSR_TC_G_S 32'sd256
`define MSR_TC_G_R 32'sd256
`define MSR_TC_G_T 32'sd60
`define MSR_TC_G_W 32'sd151
`define MSR_TC_G_E 32'sd38
`endif

// [common/msr_pkg.sv]
`default_nettype none
package msr_pkg;
   typedef enum logic [1:0] {MSR_TC, MSR_RTD, MSR_RES, MSR_DC} msr_sensor_t;
   typedef enum logic [3:0] {MSR_L, MSR_J, MSR_K, MSR_N, MSR_S, MSR_R,
      MSR_T, MSR_W, MSR_E} msr_tc_t;
   typedef enum {MSR_IDLE, MSR_WAIT, MSR_CORR} msr_state_t;
   typedef logic [2:0] msr_chan_t;
endpackage
`default_nettype wire

// [tb/msr_readout_properties.sv]
`default_nettype none
module msr_readout_properties #(parameter int SLOT_CYC = 50) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic adc_start,
   input wire msr_pkg::msr_chan_t adc_chan,
   input wire logic adc_done,
   input wire logic loop_valid,
   input wire msr_pkg::msr_chan_t loop_chan,
   input wire logic signed [15:0] loop_value,
   input wire logic [3:0] loop_fault
);
   timeunit 1ns;
   timeprecision 1ps;
   import msr_pkg::*;
   logic busy_q, busy_d;
   int gap_q, gap_d;
   always_comb
   begin
      busy_d = adc_start | (busy_q & ~adc_done);
      gap_d = adc_start ? 0 : gap_q + ((gap_q < SLOT_CYC) ? 1 : 0);
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         busy_q <= 1'b0;
         gap_q <= SLOT_CYC;
      end
      else
      begin
         busy_q <= busy_d;
         gap_q <= gap_d;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_done;
      busy_q && adc_done;
   endsequence
   sequence s_out;
      ##2 loop_valid && loop_chan == $past(adc_chan, 2);
   endsequence
   AST_BUS_OK: assert property (hreadyout && !hresp)
      else $error("bus stalled or errored");
   AST_START_PULSE: assert property (adc_start |=> !adc_start)
      else $error("start pulse too long");
   AST_IDLE_START: assert property (busy_q |-> !adc_start)
      else $error("start while converting");
   AST_SLOT: assert property (adc_start |-> gap_q >= SLOT_CYC - 1)
      else $error("starts too close");
   AST_DONE_OUT: assert property (s_done |-> s_out)
      else $error("no result two cycles after done");
   AST_OUT_PULSE: assert property (loop_valid |=> !loop_valid)
      else $error("result pulse too long");
   AST_NEXT_CHAN: assert property (loop_valid |-> adc_chan == loop_chan + 3'h1)
      else $error("channel order broken");
   AST_HOLD: assert property (!loop_valid |->
      $stable(loop_value) && $stable(loop_fault))
      else $error("result changed between updates");
   AST_CHAN_HOLD: assert property ($changed(adc_chan) |-> loop_valid)
      else $error("channel moved mid conversion");
endmodule
bind msr_readout msr_readout_properties #(.SLOT_CYC(SLOT_CYC)) u_props (
   .mclk(mclk), .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp),
   .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
   .loop_valid(loop_valid), .loop_chan(loop_chan),
   .loop_value(loop_value), .loop_fault(loop_fault));
`default_nettype wire

// [tb/msr_adc_model.sv]
`default_nettype none
module msr_adc_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic adc_start,
   input wire msr_pkg::msr_chan_t adc_chan,
   output logic adc_done,
   output logic signed [15:0] adc_data,
   output logic adc_open,
   output logic [15:0] adc_lead
);
   timeunit 1ns;
   timeprecision 1ps;
   import msr_pkg::*;
   logic signed [15:0] raw [8];
   logic opn [8];
   logic [15:0] lead [8];
   msr_chan_t ch;
   int cnt;
   logic busy;
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         busy <= 1'b0;
         adc_done <= 1'b0;
         adc_data <= 16'h0;
         adc_open <= 1'b0;
         adc_lead <= 16'h0;
      end
      else
      begin
         adc_done <= 1'b0;
         // Lines carry junk outside the done cycle
         adc_data <= ~adc_data;
         adc_open <= ~adc_open;
         adc_lead <= ~adc_lead;
         if (adc_start)
         begin
            ch <= adc_chan;
            // Upper channels outlast a slot
            cnt <= 2 + 9 * adc_chan;
            busy <= 1'b1;
         end
         else if (busy && cnt == 0)
         begin
            adc_done <= 1'b1;
            adc_data <= raw[ch];
            adc_open <= opn[ch];
            adc_lead <= lead[ch];
            busy <= 1'b0;
         end
         else if (busy)
            cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// [tb/msr_readout_tb_top.sv]
`default_nettype none
module msr_readout_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import msr_pkg::*;
   typedef struct {logic [7:0] cfg; logic [15:0] raw, lead; logic opn;
      logic [15:0] val; logic [3:0] flt;} msr_row_t;
   msr_row_t rows [8] = '{
      '{8'h18, 16'h4E20, 16'h0, 1'b0, 16'h0FA0, 4'h8},
      '{8'h08, 16'hF830, 16'h0, 1'b0, 16'h0000, 4'h2},
      '{8'h50, 16'h0000, 16'h0, 1'b0, 16'h0140, 4'h0},
      '{8'h01, 16'h0190, 16'h0, 1'b0, 16'hFC18, 4'hC},
      '{8'h81, 16'h05DC, 16'h64, 1'b0, 16'h030C, 4'h0},
      '{8'h02, 16'h0BB8, 16'h0, 1'b1, 16'h0BB8, 4'h1},
      '{8'h03, 16'hD8F1, 16'h0, 1'b0, 16'hD8F1, 4'h0},
      '{8'h03, 16'h00C8, 16'h0, 1'b0, 16'h00DB, 4'h0}};
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hready, hreadyout, hresp, adc_start, adc_done, adc_open;
   logic loop_valid, irq;
   logic signed [15:0] adc_data, loop_value;
   logic [15:0] adc_lead;
   logic [3:0] loop_fault;
   logic [7:0] loop_cfg;
   msr_chan_t adc_chan, loop_chan;
   int bad_count = 0;
   int n_checks = 0;
   int i;
   assign hready = hreadyout;
   always #5 mclk = ~mclk;
   msr_readout #(.SLOT_CYC(50)) dut (.mclk(mclk), .rst_b(rst_b),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
      .adc_open(adc_open), .adc_lead(adc_lead), .loop_valid(loop_valid),
      .loop_chan(loop_chan), .loop_value(loop_value),
      .loop_fault(loop_fault), .loop_cfg(loop_cfg), .irq(irq));
   msr_adc_model u_adc (.mclk(mclk), .rst_b(rst_b), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
      .adc_open(adc_open), .adc_lead(adc_lead));
   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Selector instead of a reference keeps free simulators happy
   task automatic wt(input bit on_loop);
      int k;
      for (k = 0; k < 3000; k++)
      begin
         @(posedge mclk);
         if ((on_loop ? loop_valid : hready) === 1'b1)
            return;
      end
      bad_count++;
      report_and_stop();
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wt(1'b0);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wt(1'b0);
      rd = hrdata;
   endtask
   initial
   begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      chk("irq", 0, irq);
      ahb(0, 32'h0C, 0);
      chk("cfg", 0, rd);
      for (i = 0; i < 8; i++)
      begin
         u_adc.raw[i] = rows[i].raw;
         u_adc.opn[i] = rows[i].opn;
         u_adc.lead[i] = rows[i].lead;
         ahb(1, 32'(4 * i), 32'(rows[i].cfg));
         ahb(1, 32'(72 + 16 * i), (i == 7) ? 32'h64 : 32'h1);
         ahb(1, 32'(76 + 16 * i), (i == 7) ? 32'h70 : 32'h1);
      end
      ahb(1, 32'hB4, 32'h5);
      ahb(1, 32'hE4, 32'hFF);
      ahb(1, 32'hEC, 32'h1);
      for (i = 0; i < 8; i++)
      begin
         wt(1'b1);
         chk("chan", 32'(i), 32'(loop_chan));
         chk("value", 32'(rows[i].val), {16'h0, loop_value});
         chk("fault", 32'(rows[i].flt), 32'(loop_fault));
         chk("lcfg", 32'(rows[i].cfg), 32'(loop_cfg));
      end
      for (i = 0; i < 8; i++)
      begin
         ahb(0, 32'(192 + 4 * i), 0);
         chk("res", {12'h0, rows[i].flt, rows[i].val}, rd);
      end
      ahb(0, 32'hE0, 0);
      chk("stat", 32'h2BFF, rd);
      chk("irq", 1, irq);
      ahb(1, 32'hE4, 32'h0);
      // Enable lands at the data-phase edge; irq settles after it
      @(posedge mclk);
      chk("irq", 0, irq);
      ahb(1, 32'hE4, 32'hFF);
      ahb(1, 32'hEC, 32'h0);
      repeat (100) @(posedge mclk);
      ahb(1, 32'hE8, 32'hFFFF);
      ahb(0, 32'hE0, 0);
      chk("stat", 0, rd);
      chk("irq", 0, irq);
      ahb(1, 32'hC0, 32'hFFFF);
      ahb(0, 32'hC0, 0);
      chk("ro", {12'h0, rows[0].flt, rows[0].val}, rd);
      ahb(0, 32'hF0, 0);
      chk("unmap", 0, rd);
      rst_b <= 1'b0;
      @(posedge mclk);
      rst_b <= 1'b1;
      ahb(0, 32'h0, 0);
      chk("cfg", 0, rd);
      chk("lval", 0, {16'h0, loop_value});
      chk("irq", 0, irq);
      report_and_stop();
   end
endmodule
`default_nettype wire
